// file: rtl/tws_defs.vh
// constants for the three-wire serial port
`ifndef TWS_DEFS_VH
`define TWS_DEFS_VH
`define TWS_ADDR_MODE        16'hFFB0
`define TWS_ADDR_DATA        16'hFFB1
`define TWS_ADDR_STATUS      16'hFFB2
`define TWS_MODE_RESET       8'h00
`define TWS_MODE_WMASK       8'h87
`define TWS_BIT_ENABLE       7
`define TWS_BIT_RXONLY       2
`define TWS_BIT_CSEL_HI      1
`define TWS_BIT_CSEL_LO      0
`define TWS_CSEL_EXT         2'h0
`define TWS_CSEL_DIV10       2'h1
`define TWS_CSEL_DIV11       2'h2
`define TWS_CSEL_SUB1        2'h3
`define TWS_DIV10_HALF       10'h1FF
`define TWS_DIV11_HALF       11'h3FF
`define TWS_BITS_PER_FRAME   4'h8
`endif

// file: rtl/tws_rate_gen.v
// half-period enable generator for the internal serial clock taps
`timescale 1ns/1ps
module tws_rate_gen (
   input  wire       sys_clk,
   input  wire       rstn,
   input  wire       sub_clock_one,
   input  wire       sub_clock_two,
   input  wire       run,
   input  wire [1:0] clock_select,
   output reg        half_tick
);
`include "tws_defs.vh"
   reg  [10:0] div_cnt;
   reg         one_d;
   reg         two_d;
   wire        two_rise;
   wire        one_edge;
   assign two_rise = sub_clock_two & ~two_d;
   // both edges of the undivided tap give one full clock per period
   assign one_edge = sub_clock_one ^ one_d;
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_cnt   <= 11'h000;
         one_d     <= 1'b0;
         two_d     <= 1'b0;
         half_tick <= 1'b0;
      end else begin
         one_d     <= sub_clock_one;
         two_d     <= sub_clock_two;
         half_tick <= 1'b0;
         if (!run) begin
            div_cnt <= 11'h000;
         end else begin
            case (clock_select)
               `TWS_CSEL_DIV10: begin
                  if (two_rise) begin
                     if (div_cnt[9:0] == `TWS_DIV10_HALF) begin
                        div_cnt   <= 11'h000;
                        half_tick <= 1'b1;
                     end else begin
                        div_cnt <= div_cnt + 11'h001;
                     end
                  end
               end
               `TWS_CSEL_DIV11: begin
                  if (two_rise) begin
                     if (div_cnt == `TWS_DIV11_HALF) begin
                        div_cnt   <= 11'h000;
                        half_tick <= 1'b1;
                     end else begin
                        div_cnt <= div_cnt + 11'h001;
                     end
                  end
               end
               `TWS_CSEL_SUB1: begin
                  half_tick <= one_edge;
               end
               default: begin
                  div_cnt <= 11'h000;
               end
            endcase
         end
      end
   end
endmodule // tws_rate_gen

// file: rtl/tws_edge_detect.v
// edge finder for the external serial clock, sampled on sys_clk
`timescale 1ns/1ps
module tws_edge_detect (
   input  wire sys_clk,
   input  wire rstn,
   input  wire pin_in,
   output wire fall,
   output wire rise
);
   reg prev;
   // idle level is high so a reset-time edge is not mistaken for a rise
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prev <= 1'b1;
      end else begin
         prev <= pin_in;
      end
   end
   assign fall = prev & ~pin_in;
   assign rise = ~prev & pin_in;
endmodule // tws_edge_detect

// file: rtl/tws_serial_port.v
// three-wire serial port: mode register, shift register and bit engine
// Contract
// - 8-bit shift register converts parallel to serial in step with serial clock.
// - shift register has no defined reset value.
// - reset clears the mode register to zero.
// - enable bit 7 disables or enables shift operation.
// - mode bit selects transmit/both when 0, receive-only when 1.
// - clock select: external, sub two /2^10, sub two /2^11, sub one.
// - disabled port does no transfer and releases its three pins.
// - each transfer moves exactly eight bits in step with the clock.
// - shift on falling clock edge; output latch drives the serial out pin.
// - serial in is captured on the rising clock edge.
// - most significant bit goes first on both lines.
// - after the eighth bit shifting halts and an end flag sets.
// - new transfer only when enabled and the clock rests high.
// - enabled transmit mode: writing the shift register starts a transfer.
// - enabled receive-only mode: reading the shift register starts a transfer.
// - a write while disabled does not start a transfer when enabled later.
`timescale 1ns/1ps
module tws_serial_port (
   input  wire        sys_clk,
   input  wire        rstn,
   input  wire [15:0] reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [7:0]  reg_rdata,
   input  wire        sub_clock_one,
   input  wire        sub_clock_two,
   input  wire        serial_clock_pin_in,
   output wire        serial_clock_pin_out,
   output wire        serial_clock_pin_oe,
   output wire        serial_out_pin_out,
   output wire        serial_out_pin_oe,
   input  wire        serial_in_pin,
   output wire        port_released,
   output wire        transfer_busy,
   output reg         transfer_end
);
`include "tws_defs.vh"
   // ****************************************
   // register decode
   // ****************************************
   reg  [7:0] serial_mode_control;
   reg  [7:0] serial_shift_data;
   reg        out_latch;
   reg        busy;
   reg        sck_level;
   reg        phase_low;
   reg  [3:0] bit_cnt;
   wire       shift_enable;
   wire       rx_only;
   wire [1:0] clock_select;
   wire       ext_clock;
   wire       wr_mode;
   wire       wr_data;
   wire       rd_data;
   wire       rd_status;
   wire       start;
   wire       half_tick;
   wire       ext_fall;
   wire       ext_rise;
   wire       do_fall;
   wire       do_rise;
   wire       clock_resting;

   function hit;
      input [15:0] addr;
      input [15:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   assign shift_enable = serial_mode_control[`TWS_BIT_ENABLE];
   assign rx_only      = serial_mode_control[`TWS_BIT_RXONLY];
   assign clock_select = {serial_mode_control[`TWS_BIT_CSEL_HI],
                          serial_mode_control[`TWS_BIT_CSEL_LO]};
   assign ext_clock    = (clock_select == `TWS_CSEL_EXT);
   assign wr_mode      = reg_write & hit(reg_addr, `TWS_ADDR_MODE);
   assign wr_data      = reg_write & hit(reg_addr, `TWS_ADDR_DATA);
   assign rd_data      = reg_read & hit(reg_addr, `TWS_ADDR_DATA);
   assign rd_status    = reg_read & hit(reg_addr, `TWS_ADDR_STATUS);
   // external clock must rest high before a new frame
   assign clock_resting = ext_clock ? serial_clock_pin_in : sck_level;
   // start only from the access itself; enabling later starts nothing
   assign start = shift_enable & ~busy & clock_resting &
                  (rx_only ? rd_data : wr_data);

   // ****************************************
   // clock sources
   // ****************************************
   tws_rate_gen u_rate (
      .sys_clk       (sys_clk),
      .rstn          (rstn),
      .sub_clock_one (sub_clock_one),
      .sub_clock_two (sub_clock_two),
      .run           (busy),
      .clock_select  (clock_select),
      .half_tick     (half_tick)
   );

   tws_edge_detect u_edge (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .pin_in  (serial_clock_pin_in),
      .fall    (ext_fall),
      .rise    (ext_rise)
   );

   assign do_fall = busy & (ext_clock ? ext_fall : (half_tick & ~phase_low));
   assign do_rise = busy & (ext_clock ? (ext_rise & phase_low) : (half_tick & phase_low));

   // ****************************************
   // mode register
   // ****************************************
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         serial_mode_control <= `TWS_MODE_RESET;
      end else if (wr_mode) begin
         // bits 3..6 are held at zero regardless of what is written
         serial_mode_control <= reg_wdata & `TWS_MODE_WMASK;
      end
   end

   // ****************************************
   // shift engine
   // ****************************************
   // data register has no reset on purpose; its content is undefined after reset
   always @(posedge sys_clk) begin
      if (wr_data && !busy) begin
         serial_shift_data <= reg_wdata;
      end else if (do_rise) begin
         serial_shift_data <= {serial_shift_data[6:0], serial_in_pin};
      end
   end

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         busy         <= 1'b0;
         sck_level    <= 1'b1;
         phase_low    <= 1'b0;
         bit_cnt      <= 4'h0;
         out_latch    <= 1'b0;
         transfer_end <= 1'b0;
      end else begin
         transfer_end <= 1'b0;
         if (!shift_enable) begin
            busy      <= 1'b0;
            sck_level <= 1'b1;
            phase_low <= 1'b0;
            bit_cnt   <= 4'h0;
         end else if (start) begin
            busy      <= 1'b1;
            phase_low <= 1'b0;
            bit_cnt   <= 4'h0;
         end else if (do_fall) begin
            sck_level <= 1'b0;
            phase_low <= 1'b1;
            out_latch <= serial_shift_data[7];
         end else if (do_rise) begin
            sck_level <= 1'b1;
            phase_low <= 1'b0;
            if (bit_cnt == `TWS_BITS_PER_FRAME - 4'h1) begin
               busy         <= 1'b0;
               transfer_end <= 1'b1;
               bit_cnt      <= 4'h0;
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
            end
         end
      end
   end

   // ****************************************
   // pins and read port
   // ****************************************
   // pins go back to the port logic while the port is stopped
   assign port_released        = ~shift_enable;
   assign serial_clock_pin_out = sck_level;
   assign serial_clock_pin_oe  = shift_enable & ~ext_clock;
   assign serial_out_pin_out   = out_latch;
   assign serial_out_pin_oe    = shift_enable & ~rx_only;
   assign transfer_busy        = busy;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         if (hit(reg_addr, `TWS_ADDR_MODE)) begin
            reg_rdata <= serial_mode_control;
         end else if (rd_data) begin
            reg_rdata <= serial_shift_data;
         end else if (rd_status) begin
            reg_rdata <= {7'h00, busy};
         end else begin
            reg_rdata <= 8'h00;
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule // tws_serial_port

// file: verif/tws_properties.sv
// pin and strobe assertions for the serial port
`timescale 1ns/1ps
`include "tws_defs.vh"
module tws_properties (
   input wire        sys_clk,
   input wire        rstn,
   input wire [15:0] reg_addr,
   input wire        reg_write,
   input wire        serial_clock_pin_out,
   input wire        serial_clock_pin_oe,
   input wire        serial_out_pin_out,
   input wire        serial_out_pin_oe,
   input wire        port_released,
   input wire        transfer_busy,
   input wire        transfer_end
);
   reg [3:0] falls;
   reg       sck_q;
   reg       busy_q;
   // falls counted per frame; restart on busy rise
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         falls  <= 4'h0;
         sck_q  <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         sck_q  <= serial_clock_pin_out;
         busy_q <= transfer_busy;
         if (transfer_busy && !busy_q)
            falls <= 4'h0;
         else if (sck_q && !serial_clock_pin_out)
            falls <= falls + 4'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   idle_clock_high_a: assert property (!transfer_busy && !$past(transfer_busy) |-> serial_clock_pin_out)
      else $error("clock low while idle");
   released_pins_a: assert property (port_released |-> !serial_clock_pin_oe && !serial_out_pin_oe)
      else $error("pins driven while released");
   released_quiet_a: assert property (port_released && $past(port_released) |-> !transfer_busy)
      else $error("busy while released");
   end_single_a: assert property (transfer_end |=> !transfer_end)
      else $error("end pulse too long");
   end_in_frame_a: assert property (transfer_end |-> $past(transfer_busy))
      else $error("end without frame");
   eight_falls_a: assert property (transfer_end && serial_clock_pin_oe |-> falls == 4'h8)
      else $error("clock pulse count wrong");
   shift_on_fall_a: assert property (transfer_busy && $past(transfer_busy) && serial_clock_pin_oe
      && $changed(serial_out_pin_out) |-> !serial_clock_pin_out) else $error("out bit moved on high clock");
   write_starts_a: assert property (reg_write && reg_addr == `TWS_ADDR_DATA && serial_out_pin_oe
      && serial_clock_pin_oe && serial_clock_pin_out && !transfer_busy |=> transfer_busy) else $error("no start");
endmodule // tws_properties
bind tws_serial_port tws_properties i_tws_properties (.sys_clk, .rstn, .reg_addr, .reg_write,
   .serial_clock_pin_out, .serial_clock_pin_oe, .serial_out_pin_out, .serial_out_pin_oe,
   .port_released, .transfer_busy, .transfer_end);

// file: verif/tws_peer.sv
// far-side model: clocked serial peripheral, msb first
`timescale 1ns/1ps
module tws_peer (
   input  wire  sck,
   input  wire  sdo,
   output logic sdi,
   output logic ext
);
   logic [7:0] tx;
   logic [7:0] rx;
   int         nf;
   initial begin
      ext = 1'b1;
      sdi = 1'b0;
      nf  = 0;
   end
   // new bit on each fall; stale bits inverted so nothing lingers
   always @(negedge sck) begin
      sdi <= tx[7];
      tx  <= {tx[6:0], ~tx[7]};
      nf  <= nf + 1;
   end
   always @(posedge sck) rx <= {rx[6:0], sdo};
   task load(input logic [7:0] v);
      tx  = v;
      sdi = ~sdi;
   endtask
   // eight pulses, then the clock stands high
   task pulses(input int h);
      // small offset keeps every clock edge clear of a sys_clk edge
      #3;
      repeat (8) begin
         #(h) ext = 1'b0;
         #(h) ext = 1'b1;
      end
   endtask
endmodule // tws_peer

// file: verif/tb.sv
// self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`include "tws_defs.vh"
module tb;
   localparam int S1H = 10;
   logic        sys_clk, rstn, reg_write, reg_read, sub_clock_one, sub_clock_two, b;
   logic [15:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, r, d;
   wire         serial_clock_pin_out, serial_clock_pin_oe, serial_out_pin_out, serial_out_pin_oe;
   wire         port_released, transfer_busy, transfer_end, sdi, ext;
   wire         sck = serial_clock_pin_oe ? serial_clock_pin_out : ext;
   int          err_count, n_compared, k;
   logic [7:0]  mt [4] = '{8'h83, 8'h80, 8'h83, 8'h81};
   tws_serial_port i_tws_serial_port (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .sub_clock_one, .sub_clock_two, .serial_clock_pin_in(sck), .serial_clock_pin_out,
      .serial_clock_pin_oe, .serial_out_pin_out, .serial_out_pin_oe, .serial_in_pin(sdi),
      .port_released, .transfer_busy, .transfer_end);
   tws_peer i_tws_peer (.sck(sck), .sdo(serial_out_pin_out), .sdi(sdi), .ext(ext));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // slow taps offset from sys_clk edges to keep sampling clean
   initial begin
      sub_clock_one = 1'b0;
      #7 forever #250 sub_clock_one = ~sub_clock_one;
   end
   initial begin
      sub_clock_two = 1'b0;
      #3 forever #50 sub_clock_two = ~sub_clock_two;
   end
   function automatic int half_cyc(input logic [1:0] s);
      return s == `TWS_CSEL_SUB1 ? S1H : s == `TWS_CSEL_DIV10 ? (`TWS_DIV10_HALF + 1) * 4 : (`TWS_DIV11_HALF + 1) * 4;
   endfunction
   task end_sim;
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task wend;
      for (int i = 0; i < 40000 && transfer_end !== 1'b1; i++) @(posedge sys_clk) #1;
      chk({7'h0, transfer_end}, 8'h01);
   endtask
   // width of the next low clock phase, in sys_clk cycles
   task wlo(input int e);
      int n;
      n = 0;
      while (sck !== 1'b0 && n < 9000) @(posedge sys_clk) n++;
      n = 0;
      while (sck === 1'b0 && n < 9000) @(posedge sys_clk) n++;
      chk({7'h0, n >= e - 4 && n <= e + 4}, 8'h01);
   endtask
   task xfer(input logic [7:0] m, input logic [7:0] dv, input logic [7:0] p);
      int f;
      wr(`TWS_ADDR_MODE, m);
      i_tws_peer.load(p);
      f = i_tws_peer.nf;
      wr(`TWS_ADDR_DATA, dv);
      wr(`TWS_ADDR_DATA, ~dv);
      if (m[1:0] == `TWS_CSEL_EXT) i_tws_peer.pulses(200);
      else wlo(half_cyc(m[1:0]));
      wend;
      chk(i_tws_peer.rx, dv);
      rd(`TWS_ADDR_DATA, r);
      chk(r, p);
      chk(8'(i_tws_peer.nf - f), 8'h08);
   endtask
   // ********************************
   // main sequence
   // ********************************
   initial begin
      void'($urandom(32'h9956));
      {rstn, reg_write, reg_read, reg_addr, reg_wdata} = '0;
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(`TWS_ADDR_MODE, r);
      chk(r, `TWS_MODE_RESET);
      chk({port_released, serial_clock_pin_oe, serial_out_pin_oe, transfer_busy}, 8'h08);
      rd(16'hFFBF, r);
      chk(r, 8'h00);
      wr(`TWS_ADDR_MODE, 8'hFF);
      rd(`TWS_ADDR_MODE, r);
      chk(r, 8'hFF & `TWS_MODE_WMASK);
      chk({7'h0, serial_out_pin_oe}, 8'h00);
      wr(`TWS_ADDR_MODE, 8'h03);
      wr(`TWS_ADDR_DATA, 8'h5A);
      wr(`TWS_ADDR_MODE, 8'h83);
      b = 1'b0;
      repeat (40) begin
         @(posedge sys_clk);
         #1 b = b | transfer_busy;
      end
      chk({7'h0, b}, 8'h00);
      xfer(8'h83, 8'h01, 8'hFE);
      for (k = 0; k < 4; k++) xfer(mt[k], 8'($urandom), 8'($urandom));
      wr(`TWS_ADDR_MODE, 8'h87);
      d = 8'($urandom);
      i_tws_peer.load(d);
      rd(`TWS_ADDR_DATA, r);
      wend;
      i_tws_peer.load(~d);
      rd(`TWS_ADDR_DATA, r);
      chk(r, d);
      wend;
      wr(`TWS_ADDR_MODE, 8'h82);
      wr(`TWS_ADDR_DATA, 8'hA5);
      wlo(half_cyc(`TWS_CSEL_DIV11));
      wr(`TWS_ADDR_MODE, 8'h00);
      repeat (3) @(posedge sys_clk);
      #1 chk({port_released, transfer_busy, transfer_end}, 8'h04);
      end_sim;
   end
   // hang guard, about twice the expected run
   initial begin
      #(80000 * 25);
      err_count++;
      end_sim;
   end
endmodule // tb
